// ---- bench/pmcc_assertions.sv ----
// Concurrent checks on the power mode and clock controller ports.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module pmcc_assertions
  import pmcc_pkg::*;
(
  // Clock and reset
  input logic     aclk,
  input logic     aresetn,
  // Events
  input logic     halt_exec,
  input logic     wake_req,
  input logic     wdt_timeout,
  // Clock enables
  input logic     sys_clk_en,
  input logic     cpu_clk_en,
  input logic     time_base_clk_en,
  input logic     sub_clk_en,
  input logic     wdt_clk_en,
  input logic     fast_div16_en,
  input logic     fast_div64_en,
  input logic     fast_osc_on,
  // Mode and flags
  input op_mode_t op_mode,
  input logic     hold_state,
  input logic     wdt_clear,
  input logic     power_down_flag,
  input logic     timeout_flag
);
  // Longest gap between slow ticks that any build may use
  localparam int SLOW_GAP = 1000;
  logic run;
  logic lowp;

  // Mode groups; a halt only counts while the CPU runs
  assign run  = (op_mode == MODE_NORMAL) || (op_mode == MODE_SLOW);
  assign lowp = (op_mode == MODE_CLOCK_OFF_IDLE) || (op_mode == MODE_CLOCK_ON_IDLE) ||
                (op_mode == MODE_SLEEP);

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  halt_entry_a: assert property (halt_exec && run |=> lowp)
    else $error("halt did not stop the cpu");
  clock_on_idle_cpu_a: assert property (op_mode == MODE_CLOCK_ON_IDLE |-> !cpu_clk_en)
    else $error("cpu clock runs in clock-on idle");
  clock_off_idle_clk_a: assert property (op_mode == MODE_CLOCK_OFF_IDLE |-> !sys_clk_en)
    else $error("system clock runs in clock-off idle");
  sleep_clk_a: assert property (op_mode == MODE_SLEEP |->
    !sys_clk_en && !time_base_clk_en)
    else $error("clock runs in sleep");
  wdt_pulse_a: assert property (halt_exec && run |=>
    wdt_clear ##1 !wdt_clear)
    else $error("watchdog clear pulse wrong");
  pd_flags_a: assert property (halt_exec && run && !wdt_timeout |=>
    power_down_flag && !timeout_flag)
    else $error("flags wrong after halt");
  mode_hold_a: assert property (lowp && !wake_req |=>
    $stable(op_mode) && hold_state)
    else $error("low power mode not held");
  slow_fast_a: assert property (op_mode == MODE_SLOW |->
    !fast_osc_on && !fast_div16_en && !fast_div64_en)
    else $error("fast clock alive in slow mode");
  wdt_sleep_a: assert property (op_mode == MODE_SLEEP |->
    ##[0:SLOW_GAP] wdt_clk_en)
    else $error("watchdog clock stopped in sleep");
  clock_off_idle_tick_a: assert property (op_mode == MODE_CLOCK_OFF_IDLE |->
    ##[0:SLOW_GAP] (sub_clk_en && time_base_clk_en))
    else $error("slow clocks stopped in clock-off idle");
endmodule : pmcc_assertions

bind power_mode_clock_controller pmcc_assertions u_chk (.aclk, .aresetn,
  .halt_exec, .wake_req, .wdt_timeout, .sys_clk_en, .cpu_clk_en,
  .time_base_clk_en, .sub_clk_en, .wdt_clk_en, .fast_div16_en,
  .fast_div64_en, .fast_osc_on,
  .op_mode, .hold_state, .wdt_clear, .power_down_flag, .timeout_flag);

// ---- bench/testbench.sv ----
// Self-checking bench for the power mode and clock controller.
// Assumes the checker is bound in; drives the AXI4-Lite port itself.
`timescale 1ns/1ps
module testbench;
  import pmcc_pkg::*;
  localparam int HS = 8;
  localparam int LS = 24;
  localparam int SD = 4;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  ev_q; // halt, wake, clear watchdog, timeout
  logic        sys_en, cpu_en, tb_en, d16, d64, fast_on, wclr, pd, to, hold;
  op_mode_t    mode;
  int          n_fail, compares, seed;

  // Short start-up counts keep the run brief
  power_mode_clock_controller #(.HIGH_START_CYC(HS), .LOW_START_CYC(LS),
    .SLOW_DIV(SD)) u_power_mode_clock_controller (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .halt_exec(ev_q[0]), .wake_req(ev_q[1]), .clr_wdt_exec(ev_q[2]),
    .wdt_timeout(ev_q[3]), .sys_clk_en(sys_en), .cpu_clk_en(cpu_en),
    .time_base_clk_en(tb_en), .sub_clk_en(), .wdt_clk_en(),
    .fast_div16_en(d16), .fast_div64_en(d64), .fast_osc_on(fast_on),
    .op_mode(mode), .hold_state(hold), .wdt_clear(wclr),
    .power_down_flag(pd), .timeout_flag(to));

  task automatic print_verdict;
    $display("counts: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_mode(input op_mode_t got, input op_mode_t exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t mode=%h exp=%h", $time, got, exp);
    end
  endtask : chk_mode

  function automatic logic sig(input int w);
    case (w)
      0: return awready && wready;
      1: return bvalid;
      2: return arready;
      3: return rvalid;
      4: return sys_en;
      default: return mode == MODE_SLOW;
    endcase
  endfunction : sig

  // Sampled at the falling edge, where every output has settled
  task automatic wait_hi(input int w);
    int n;
    for (n = 0; n < 300; n++) begin
      @(negedge aclk);
      if (sig(w)) break;
    end
    if (n >= 300) begin
      n_fail++;
      $display("MISMATCH t=%0t wait ran out: %h %h", $time, n, w);
      print_verdict();
    end
  endtask : wait_hi

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    wait_hi(0);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    wait_hi(1);
    chk(bresp, er);
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    wait_hi(2);
    @(posedge aclk);
    arvalid <= 1'b0;
    rready <= 1'b1;
    wait_hi(3);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e);
  endtask : rc

  // One-cycle event pulse; returns once the answer has landed
  task automatic ev(input int k);
    @(posedge aclk);
    ev_q[k] <= 1'b1;
    @(posedge aclk);
    ev_q[k] <= 1'b0;
    @(negedge aclk);
  endtask : ev

  // Cycles between two system clock enables
  task automatic per(output int p);
    wait_hi(4);
    for (p = 1; p < 300; p++) begin
      @(negedge aclk);
      if (sys_en) break;
    end
  endtask : per

  function automatic int exp_per(input logic hl, input logic [2:0] c);
    if (hl) return 1;
    if (c < 3'h2) return SD;
    return 64 >> (c - 3'h2);
  endfunction : exp_per

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  initial begin
    int          p, i;
    logic [31:0] d, rn;
    logic [1:0]  r;
    logic        idl, kp;
    op_mode_t    em;
    seed = 75;
    n_fail = 0;
    compares = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, ev_q} = 52'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, then a slow switch before the slow source is ready
    rc(8'h00, 32'h03);
    rc(8'h04, 32'h00);
    rc(8'h08, 32'h00);
    wr(8'h00, 32'h02, RESP_OKAY);
    chk_mode(mode, MODE_NORMAL);
    rc(8'h00, 32'h06);
    wait_hi(5);
    rc(8'h00, 32'h0A);
    wr(8'h00, 32'h03, RESP_OKAY);
    @(negedge aclk);
    chk_mode(mode, MODE_NORMAL);
    d = 32'h0;
    for (i = 0; i < 40 && !d[2]; i++) rd(8'h00, d, r);
    chk(d, 32'h0F);
    $display("test reset and slow switch done");
    // Every divider code from a random start, then the undivided clock
    rn = $random(seed);
    for (i = 0; i < 9; i++) begin
      wr(8'h00, {rn[31:8], 3'(i + rn[2:0]), rn[4:2], 1'b1, i == 8},
         RESP_OKAY);
      per(p);
      per(p);
      chk(p, exp_per(i == 8, 3'(i + rn[2:0])));
    end
    $display("test divider done");
    // Random control writes; unused bits and the status port stay put
    for (i = 0; i < 4; i++) begin
      rn = $random(seed);
      wr(8'h04, rn, RESP_OKAY);
      rc(8'h04, {24'h0, rn[7], 7'h0});
    end
    wr(8'h08, 32'h03, RESP_OKAY);
    rc(8'h08, 32'h00);
    wr(8'h0C, 32'h55, RESP_SLVERR);
    rd(8'h0C, d, r);
    chk(d, 32'h0);
    chk(r, RESP_SLVERR);
    $display("test register access done");
    // Halt in every idle/keep setting, then random ones
    for (i = 0; i < 8; i++) begin
      rn = (i < 4) ? i : $random(seed);
      {idl, kp} = rn[1:0];
      wr(8'h00, {30'h0, idl, 1'b1}, RESP_OKAY);
      wr(8'h04, {24'h0, kp, 7'h0}, RESP_OKAY);
      em = !idl ? MODE_SLEEP : (kp ? MODE_CLOCK_ON_IDLE : MODE_CLOCK_OFF_IDLE);
      ev(0);
      chk_mode(mode, em);
      chk({wclr, pd, to, cpu_en, sys_en}, {4'hC, em == MODE_CLOCK_ON_IDLE});
      ev(0);
      chk_mode(mode, em);
      if (!idl) ev(3);
      rc(8'h08, {30'h0, !idl, 1'b1});
      rc(8'h00, {28'h0, 1'b1, em == MODE_CLOCK_ON_IDLE, idl, 1'b1});
      ev(1);
      chk_mode(mode, MODE_NORMAL);
      ev(2);
      rc(8'h08, 32'h00);
    end
    $display("test halt modes done");
    print_verdict();
  end
endmodule : testbench

// ---- src/clock_tap_divider.sv ----
// Derives the divided fast-clock enables and the slow-clock tick.
// Assumes aclk is the fast oscillator; fast taps stop when fast_on is low.
`timescale 1ns/1ps
`include "pmcc_consts.svh"
module clock_tap_divider #(
  parameter int TAPS     = 6,
  parameter int SLOW_DIV = `SLOW_DIV_CYCLES
) (
  // Clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // Control
  input  wire logic            fast_on,
  // Enables: tap_en[k-1] pulses once every 2**k cycles
  output logic [TAPS-1:0]      tap_en,
  output logic                 slow_tick
);
  localparam int SW = $clog2(SLOW_DIV);

  logic [TAPS-1:0] fcnt_q;
  logic [TAPS-1:0] fcnt_d;
  logic [SW-1:0]   scnt_q;
  logic [SW-1:0]   scnt_d;

  if (TAPS < 6 || SLOW_DIV < 2) begin : g_check
    $error("clock_tap_divider: needs six taps and a slow divide of 2 up");
  end

  // Fast counter only runs with the oscillator; slow one always runs
  always_comb begin
    fcnt_d = fast_on ? fcnt_q + 1'b1 : fcnt_q;
    scnt_d = (scnt_q == SW'(SLOW_DIV - 1)) ? '0 : scnt_q + 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fcnt_q <= '0;
      scnt_q <= '0;
    end else begin
      fcnt_q <= fcnt_d;
      scnt_q <= scnt_d;
    end
  end

  // One tap per power of two
  for (genvar k = 1; k <= TAPS; k++) begin : g_tap
    assign tap_en[k-1] = fast_on & (&fcnt_q[k-1:0]);
  end

  assign slow_tick = (scnt_q == SW'(SLOW_DIV - 1));

endmodule : clock_tap_divider

// ---- src/osc_ready_timer.sv ----
// Oscillator stabilisation timer: ready rises after START_CYC enabled
// cycles and falls on the first edge after the oscillator is switched off.
`timescale 1ns/1ps
module osc_ready_timer #(
  parameter int START_CYC = 320
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Oscillator running
  input  wire logic osc_on,
  // Stable flag
  output logic      ready
);
  localparam int CW = $clog2(START_CYC + 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          rdy_q;
  logic          rdy_d;

  if (START_CYC < 1) begin : g_check
    $error("osc_ready_timer: start-up count must be at least one");
  end

  // A stopped oscillator loses stability and restarts the count
  always_comb begin
    cnt_d = cnt_q;
    rdy_d = rdy_q;
    if (!osc_on) begin
      cnt_d = '0;
      rdy_d = 1'b0;
    end else if (cnt_q == CW'(START_CYC - 1)) begin
      rdy_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
    end
  end

  assign ready = rdy_q;

endmodule : osc_ready_timer

// ---- src/pmcc_consts.svh ----
// Constants for the power mode and clock controller: offsets, fields,
// reset values and timing figures. Definitions only.
`ifndef PMCC_CONSTS_SVH
`define PMCC_CONSTS_SVH

// Register byte addresses on the register bus
`define OFS_CLOCK_MODE      8'h00
`define OFS_SYSTEM_CONTROL  8'h04
`define OFS_POWER_STATUS    8'h08

// Clock mode register fields
`define CM_DIV_HI           7
`define CM_DIV_LO           5
`define CM_LOW_READY        3
`define CM_HIGH_READY       2
`define CM_IDLE_EN          1
`define CM_HL_SEL           0
`define CM_DIV_RESET        3'h0
`define CM_IDLE_EN_RESET    1'h1
`define CM_HL_SEL_RESET     1'h1

// System control register fields
`define SC_KEEP_IN_IDLE     7
`define SC_KEEP_RESET       1'h0

// Power status register fields
`define PS_POWER_DOWN       0
`define PS_TIMEOUT          1

// Oscillator rates and start-up times
`define FAST_OSC_HZ         20000000
`define SLOW_OSC_HZ         32000
`define SLOW_DIV_CYCLES     (`FAST_OSC_HZ / `SLOW_OSC_HZ)
`define HIGH_OSC_START_US   16
`define LOW_OSC_START_US    1000
`define CLK_MHZ             (`FAST_OSC_HZ / 1000000)
`define HIGH_OSC_START_CYC  (`HIGH_OSC_START_US * `CLK_MHZ)
`define LOW_OSC_START_CYC   (`LOW_OSC_START_US * `CLK_MHZ)

`endif

// ---- src/pmcc_pkg.sv ----
// Types shared by the power mode and clock controller files.
// Assumes nothing from the constants header; the encodings below are set here.
package pmcc_pkg;

  // Operating modes, one-hot
  typedef enum logic [4:0] {
    MODE_NORMAL = 5'b00001,
    MODE_SLOW   = 5'b00010,
    MODE_CLOCK_ON_IDLE  = 5'b00100,
    MODE_CLOCK_OFF_IDLE  = 5'b01000,
    MODE_SLEEP  = 5'b10000
  } op_mode_t;

  // AXI response codes
  typedef enum logic [1:0] {
    RESP_OKAY   = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_t;

endpackage : pmcc_pkg

// ---- src/power_mode_clock_controller.sv ----
// Power mode and system clock controller with an AXI4-Lite register port.
// Assumes aclk is the fast oscillator and the CPU pulses halt_exec.
//
// Overview of operation
// [RL1] Halt, idle on, keep on: clock-on idle
// [RL2] Halt, idle on, keep off: clock-off idle
// [RL3] Halt with idle off enters sleep
// [RL4] Sleep stops system and time-base clocks
// [RL5] Power-down entry clears then resumes watchdog
// [RL6] Power-down entry sets PD, clears timeout
// [RL7] Low-power modes keep memory, registers, ports
// [RL8] High/low select 1 gives undivided fast clock
// [RL9] Divider codes 000/001 select slow oscillator
// [RL10] Select 1 or codes 010-111 mean fast
// [RL11] Slow selection stops fast oscillator and taps
// [RL12] Read-only low-oscillator-ready flag at bit 3
// [RL13] Slow switch completes once slow oscillator stable
// [RL14] Software polls high-ready before trusting speed
// [RL15] Keep-in-idle bit sits at control bit 7
// [RL16] Unimplemented control and mode bits read zero
// [RL17] Fast 20 MHz, slow 32 kHz sources
// [RL18] Codes 010-111 divide by 64 down to 2
// [RL19] High-ready clears off, sets once restabilised
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "pmcc_consts.svh"
module power_mode_clock_controller
  import pmcc_pkg::*;
#(
  parameter int HIGH_START_CYC = `HIGH_OSC_START_CYC,
  parameter int LOW_START_CYC  = `LOW_OSC_START_CYC,
  parameter int SLOW_DIV       = `SLOW_DIV_CYCLES
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // CPU and watchdog events
  input  wire logic        halt_exec,
  input  wire logic        wake_req,
  input  wire logic        clr_wdt_exec,
  input  wire logic        wdt_timeout,
  // Clock enables
  output logic             sys_clk_en,
  output logic             cpu_clk_en,
  output logic             time_base_clk_en,
  output logic             sub_clk_en,
  output logic             wdt_clk_en,
  output logic             fast_div16_en,
  output logic             fast_div64_en,
  output logic             fast_osc_on,
  // Mode and status
  output op_mode_t         op_mode,
  output logic             hold_state,
  output logic             wdt_clear,
  output logic             power_down_flag,
  output logic             timeout_flag
);

  // Register state
  logic [2:0]  divider_select_q, divider_select_d;
  logic        high_low_clock_select_q, high_low_clock_select_d;
  logic        idle_enable_q, idle_enable_d;
  logic        sysclk_keep_in_idle_q, sysclk_keep_in_idle_d;
  logic        pd_q, pd_d;
  logic        to_q, to_d;
  // Mode state
  op_mode_t    mode_q, mode_d;
  logic        src_slow_q, src_slow_d;
  logic        wdt_clear_q, wdt_clear_d;
  // Bus state
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  logic        rvalid_q, rvalid_d;
  logic [1:0]  rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  // Derived signals
  logic [5:0]  tap_en;
  logic        slow_tick;
  logic        low_osc_ready;
  logic        high_osc_ready;
  logic        slow_req;
  logic        running;
  logic        halt_go;
  logic        fast_tick;
  logic        wr_go;
  logic        rd_go;
  logic [7:0]  clock_mode_rd;
  logic [7:0]  system_control_rd;

  // [RL17] Slow tick from fast clock
  clock_tap_divider #(
    .TAPS     (6),
    .SLOW_DIV (SLOW_DIV)
  ) u_div (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .fast_on   (fast_osc_on),
    .tap_en    (tap_en),
    .slow_tick (slow_tick)
  );

  // [RL19] High-ready follows restarts
  osc_ready_timer #(
    .START_CYC (HIGH_START_CYC)
  ) u_high_rdy (
    .aclk    (aclk),
    .aresetn (aresetn),
    .osc_on  (fast_osc_on),
    .ready   (high_osc_ready)
  );

  // Slow oscillator always runs, it clocks the watchdog
  osc_ready_timer #(
    .START_CYC (LOW_START_CYC)
  ) u_low_rdy (
    .aclk    (aclk),
    .aresetn (aresetn),
    .osc_on  (1'b1),
    .ready   (low_osc_ready)
  );

  // [RL9] Slow codes when low select
  assign slow_req = !high_low_clock_select_q &&
                    (divider_select_q[2:1] == 2'b00);
  assign running  = (mode_q == MODE_NORMAL) || (mode_q == MODE_SLOW);
  assign halt_go  = running && halt_exec;

  // [RL8] Select 1 gives undivided clock
  // [RL18] Codes 2..7 pick divide 64..2
  always_comb begin
    fast_tick = 1'b1;
    if (!high_low_clock_select_q) begin
      // Slow codes never index the taps, so no out-of-range read
      if (divider_select_q[2:1] == 2'b00) begin
        fast_tick = 1'b0;
      end else begin
        fast_tick = tap_en[3'd7 - divider_select_q];
      end
    end
  end

  // Mode sequencing
  always_comb begin
    mode_d      = mode_q;
    src_slow_d  = src_slow_q;
    wdt_clear_d = 1'b0;
    case (mode_q)
      MODE_NORMAL, MODE_SLOW: begin
        if (halt_exec) begin
          // [RL5] Clear watchdog on entry
          wdt_clear_d = 1'b1;
          // [RL3] Idle off means sleep
          if (!idle_enable_q) begin
            mode_d = MODE_SLEEP;
          // [RL1] Keep bit gives clock-on idle
          end else if (sysclk_keep_in_idle_q) begin
            mode_d = MODE_CLOCK_ON_IDLE;
          // [RL2] Otherwise clock-off idle
          end else begin
            mode_d = MODE_CLOCK_OFF_IDLE;
          end
        // [RL13] Wait for slow stability
        end else if (slow_req && low_osc_ready) begin
          mode_d     = MODE_SLOW;
          src_slow_d = 1'b1;
        // [RL10] Return to fast oscillator
        end else if (!slow_req) begin
          mode_d     = MODE_NORMAL;
          src_slow_d = 1'b0;
        end
      end
      MODE_CLOCK_ON_IDLE, MODE_CLOCK_OFF_IDLE, MODE_SLEEP: begin
        // Resume in the mode held before the halt
        if (wake_req) begin
          mode_d = src_slow_q ? MODE_SLOW : MODE_NORMAL;
        end
      end
      default: begin
        mode_d = MODE_NORMAL;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q      <= MODE_NORMAL;
      src_slow_q  <= 1'b0;
      wdt_clear_q <= 1'b0;
    end else begin
      mode_q      <= mode_d;
      src_slow_q  <= src_slow_d;
      wdt_clear_q <= wdt_clear_d;
    end
  end

  // [RL11] Fast oscillator off when slow
  assign fast_osc_on = (mode_q == MODE_NORMAL) ||
                       ((mode_q == MODE_CLOCK_ON_IDLE) && !src_slow_q);

  // Clock enables per mode
  always_comb begin
    sys_clk_en = 1'b0;
    case (mode_q)
      MODE_NORMAL: sys_clk_en = fast_tick;
      MODE_SLOW:   sys_clk_en = slow_tick;
      // [RL1] System clock stays on
      MODE_CLOCK_ON_IDLE:  sys_clk_en = src_slow_q ? slow_tick : fast_tick;
      default:     sys_clk_en = 1'b0;
    endcase
  end

  // [RL7] CPU frozen, state held
  assign cpu_clk_en       = running && sys_clk_en;
  assign hold_state       = !running;
  // [RL4] Sleep stops the time base
  assign time_base_clk_en = slow_tick && (mode_q != MODE_SLEEP);
  assign sub_clk_en       = slow_tick;
  assign wdt_clk_en       = slow_tick;
  // [RL11] Timer taps stop with the oscillator
  assign fast_div16_en    = tap_en[3];
  assign fast_div64_en    = tap_en[5];
  assign op_mode          = mode_q;
  assign wdt_clear        = wdt_clear_q;

  // [RL6] Power-down and timeout flags; a set beats a same-cycle clear
  always_comb begin
    pd_d = pd_q;
    to_d = to_q;
    if (clr_wdt_exec) begin
      pd_d = 1'b0;
      to_d = 1'b0;
    end
    if (halt_go) begin
      pd_d = 1'b1;
      to_d = 1'b0;
    end
    if (wdt_timeout) begin
      to_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd_q <= 1'b0;
      to_q <= 1'b0;
    end else begin
      pd_q <= pd_d;
      to_q <= to_d;
    end
  end

  assign power_down_flag = pd_q;
  assign timeout_flag    = to_q;

  // Write channel: address and data are taken together, one at a time
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign rd_go         = s_axi_arvalid && !rvalid_q;
  assign s_axi_arready = rd_go;

  // [RL12] Ready flags read-only
  // [RL16] Unused bits read zero
  assign clock_mode_rd = {divider_select_q, 1'b0, low_osc_ready,
                          high_osc_ready, idle_enable_q,
                          high_low_clock_select_q};
  // [RL15] Keep bit at position 7
  assign system_control_rd = {sysclk_keep_in_idle_q, 7'h00};

  // Register writes and responses
  always_comb begin
    divider_select_d        = divider_select_q;
    high_low_clock_select_d = high_low_clock_select_q;
    idle_enable_d           = idle_enable_q;
    sysclk_keep_in_idle_d   = sysclk_keep_in_idle_q;
    bvalid_d                = bvalid_q && !s_axi_bready;
    bresp_d                 = bresp_q;
    if (wr_go) begin
      bvalid_d = 1'b1;
      bresp_d  = RESP_OKAY;
      if (s_axi_awaddr == `OFS_CLOCK_MODE) begin
        if (s_axi_wstrb[0]) begin
          divider_select_d        = s_axi_wdata[`CM_DIV_HI:`CM_DIV_LO];
          idle_enable_d           = s_axi_wdata[`CM_IDLE_EN];
          high_low_clock_select_d = s_axi_wdata[`CM_HL_SEL];
        end
      end else if (s_axi_awaddr == `OFS_SYSTEM_CONTROL) begin
        if (s_axi_wstrb[0]) begin
          sysclk_keep_in_idle_d = s_axi_wdata[`SC_KEEP_IN_IDLE];
        end
      end else if (s_axi_awaddr == `OFS_POWER_STATUS) begin
        bresp_d = RESP_OKAY; // Read-only, writes ignored
      end else begin
        bresp_d = RESP_SLVERR;
      end
    end
  end

  // Register reads
  always_comb begin
    rvalid_d = rvalid_q && !s_axi_rready;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    if (rd_go) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      if (s_axi_araddr == `OFS_CLOCK_MODE) begin
        rdata_d[7:0] = clock_mode_rd;
      end else if (s_axi_araddr == `OFS_SYSTEM_CONTROL) begin
        rdata_d[7:0] = system_control_rd;
      end else if (s_axi_araddr == `OFS_POWER_STATUS) begin
        rdata_d[`PS_POWER_DOWN] = pd_q;
        rdata_d[`PS_TIMEOUT]    = to_q;
      end else begin
        rresp_d = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      divider_select_q        <= `CM_DIV_RESET;
      high_low_clock_select_q <= `CM_HL_SEL_RESET;
      idle_enable_q           <= `CM_IDLE_EN_RESET;
      sysclk_keep_in_idle_q   <= `SC_KEEP_RESET;
      bvalid_q                <= 1'b0;
      bresp_q                 <= 2'b00;
      rvalid_q                <= 1'b0;
      rresp_q                 <= 2'b00;
      rdata_q                 <= 32'h0000_0000;
    end else begin
      divider_select_q        <= divider_select_d;
      high_low_clock_select_q <= high_low_clock_select_d;
      idle_enable_q           <= idle_enable_d;
      sysclk_keep_in_idle_q   <= sysclk_keep_in_idle_d;
      bvalid_q                <= bvalid_d;
      bresp_q                 <= bresp_d;
      rvalid_q                <= rvalid_d;
      rresp_q                 <= rresp_d;
      rdata_q                 <= rdata_d;
    end
  end

  // [RL14] Software polls high-ready before full speed
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;

endmodule : power_mode_clock_controller
